// File: core/wdctl_top.sv
/*
 * Watchdog control timer: control register, timed-access unlock, interrupt
 * status and mask, and an AHB-Lite slave in front of them.
 * Assumes one 20 MHz clock, resetn for every reset type and por_n asserted
 * only on power-on; the system turns dog_reset_req into a reset.
 */
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps

// Behaviour
// [RULE_01] With all four config enable bits set the block is a timer whose count runs only while the run bit is set; otherwise the run bit does nothing.
// [RULE_02] Writing one to the count clear bit zeroes the count, writing zero leaves it alone.
// [RULE_03] The count clear bit reads one while a clear is pending and zero once the count is cleared.
// [RULE_04] A counter overflow sets the timeout flag, which holds until software clears it.
// [RULE_05] In timer use the sleep-run bit halts the count in idle or power-down when zero and keeps it running when one.
// [RULE_06] A watchdog timeout that causes a reset sets the watchdog reset flag for software to clear.
// [RULE_07] Power-on reset clears the watchdog reset flag, a watchdog reset sets it, other resets keep it.
// [RULE_08] The three-bit prescale select picks a division from 1/1 to 1/256 and defaults to the largest.
// [RULE_09] Power-on reset sets every prescale select bit and other resets keep them.
// [RULE_10] Control register writes count only right after the timed-access unlock sequence; others are dropped.
module wdctl_top #(
   parameter int unsigned BASE_DIV_CYC = wdctl_pkg::DOG_DIV_CYC
) (
   input  wire  logic                            core_clk,
   input  wire  logic                            resetn,
   input  wire  logic                            por_n,
   input  wire  logic                            hsel,
   input  wire  logic [wdctl_pkg::ADDR_W-1:0]    haddr,
   input  wire  logic [1:0]                      htrans,
   input  wire  logic                            hwrite,
   input  wire  logic [2:0]                      hsize,
   input  wire  logic [wdctl_pkg::DATA_W-1:0]    hwdata,
   input  wire  logic                            hready,
   output logic       [wdctl_pkg::DATA_W-1:0]    hrdata,
   output logic                                  hreadyout,
   output logic                                  hresp,
   input  wire  logic [wdctl_pkg::CFG_W-1:0]     timer_config_enable,
   input  wire  logic                            sleep_mode,
   output logic                                  irq,
   output logic                                  dog_reset_req
);
   import wdctl_pkg::*;

   wdctl_cnt_if cnt_bus ();

   // Bus pipeline state
   logic                wr_pend;
   logic [IDX_W-1:0]    wr_idx;

   // Control register fields; only dog_reset_flag and prescale_select live on por_n
   logic                counter_run_enable;
   logic                run_in_sleep;
   logic                timeout_flag;
   logic                count_clear;
   logic                dog_reset_flag;
   logic [PS_W-1:0]     prescale_select;

   // Interrupt registers
   logic [IRQ_W-1:0]    irq_status;
   logic [IRQ_W-1:0]    irq_mask;

   // Timed access
   wdctl_ta_t           ta_state;
   wdctl_ta_t           next_ta_state;
   logic [TA_CNT_W-1:0] ta_cnt;

   // Watchdog clock enable divider
   logic [DIV_W-1:0]    div_cnt;
   logic                tick;

   // Address phase decode; hsize is not checked since only words are used
   wire                 addr_ok;
   wire [IDX_W-1:0]     idx_a;
   wire                 rd_take;
   wire                 wr_take;
   assign addr_ok = hsel & htrans[1] & hready;
   assign idx_a   = haddr[IDX_W+1:2];
   assign rd_take = addr_ok & ~hwrite;
   assign wr_take = addr_ok & hwrite;

   // Data phase write decode
   wire [REG_W-1:0]     wb;
   wire                 wr_ctl_any;
   wire                 wr_ta;
   wire                 wr_mask;
   wire                 ta_open;
   wire                 wr_ctl;
   assign wb         = hwdata[REG_W-1:0];
   assign wr_ctl_any = wr_pend & (wr_idx == IDX_DOG_CONTROL);
   assign wr_ta      = wr_pend & (wr_idx == IDX_TIMED_ACCESS);
   assign wr_mask    = wr_pend & (wr_idx == IDX_IRQ_MASK);
   assign ta_open    = (ta_state == TA_OPEN);
   // [RULE_10] locked writes dropped
   assign wr_ctl     = wr_ctl_any & ta_open;

   // Operating mode and count gating
   wire                 timer_mode;
   wire                 counting;
   // [RULE_01] config selects timer
   assign timer_mode = (timer_config_enable == CFG_TIMER);
   // [RULE_05] sleep halts timer
   assign counting   = timer_mode ?
                       (counter_run_enable & (~sleep_mode | run_in_sleep)) : 1'b1;

   // Counter events
   wire                 overflow;
   wire                 clear_done;
   wire                 reset_fire;
   assign overflow   = cnt_bus.overflow;
   assign clear_done = cnt_bus.clear_done;
   // Only watchdog use turns an overflow into a reset request
   assign reset_fire = overflow & ~timer_mode;

   // Next values of the control fields; hardware sets win over software
   wire                 next_count_clear;
   wire                 next_timeout_flag;
   wire                 next_dog_reset_flag;
   // [RULE_02] write one requests clear
   assign next_count_clear    = (wr_ctl & wb[BIT_CLEAR]) | (count_clear & ~clear_done);
   // [RULE_04] overflow sets flag
   assign next_timeout_flag   = overflow | (wr_ctl ? wb[BIT_TOF] : timeout_flag);
   // [RULE_06] timeout reset sets flag
   assign next_dog_reset_flag = reset_fire | (wr_ctl ? wb[BIT_RSTF] : dog_reset_flag);

   // Interrupt next values; a read of status clears what it returned
   wire [IRQ_W-1:0]     events;
   wire                 rd_status;
   wire [IRQ_W-1:0]     next_irq_status;
   wire [IRQ_W-1:0]     next_irq_mask;
   assign events          = {clear_done, overflow};
   assign rd_status       = rd_take & (idx_a == IDX_IRQ_STATUS);
   assign next_irq_status = (rd_status ? IRQ_NONE : irq_status) | events;
   assign next_irq_mask   = wr_mask ? wb[IRQ_W-1:0] : irq_mask;

   // Read data selection
   wire [REG_W-1:0]     ctl_byte;
   wire [DATA_W-1:0]    rd_word;
   // [RULE_03] pending clear reads one
   assign ctl_byte = {counter_run_enable, count_clear, timeout_flag, run_in_sleep,
                      dog_reset_flag, prescale_select};
   assign rd_word  = (idx_a == IDX_DOG_CONTROL) ? {{(DATA_W-REG_W){1'b0}}, ctl_byte} :
                     (idx_a == IDX_IRQ_STATUS)  ? {{(DATA_W-IRQ_W){1'b0}}, irq_status} :
                     (idx_a == IDX_IRQ_MASK)    ? {{(DATA_W-IRQ_W){1'b0}}, irq_mask} :
                     {DATA_W{1'b0}};

   // Divider decode
   wire                 div_wrap;
   assign div_wrap = (div_cnt == DIV_W'(BASE_DIV_CYC - 1));

   // Counter carrier hook-up
   assign cnt_bus.tick      = tick;
   assign cnt_bus.run       = counting;
   assign cnt_bus.prescale  = prescale_select;
   assign cnt_bus.clear_req = count_clear;

   wdctl_counter u_counter (
      .core_clk (core_clk),
      .resetn   (resetn),
      .cnt_bus  (cnt_bus)
   );

   // Watchdog clock enable, one core cycle wide
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         div_cnt <= '0;
         tick    <= 1'b0;
      end else begin
         div_cnt <= div_wrap ? '0 : div_cnt + DIV_W'(1);
         tick    <= div_wrap;
      end
   end

   // Slave never stalls; read data is captured in the address phase
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wr_pend   <= 1'b0;
         wr_idx    <= '0;
         hrdata    <= '0;
         hreadyout <= 1'b0;
         hresp     <= HRESP_OKAY;
      end else begin
         wr_pend   <= wr_take;
         wr_idx    <= idx_a;
         hrdata    <= rd_take ? rd_word : '0;
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end
   end

   // Unlock sequence: key one, key two, then one control write in the window
   always_comb begin
      next_ta_state = ta_state;
      unique case (ta_state)
         TA_LOCKED: begin
            if (wr_ta) begin
               next_ta_state = (wb == TA_KEY1) ? TA_HALF : TA_LOCKED;
            end
         end
         TA_HALF: begin
            if (wr_ta) begin
               next_ta_state = (wb == TA_KEY2) ? TA_OPEN : TA_LOCKED;
            end
         end
         TA_OPEN: begin
            if (wr_ta) begin
               next_ta_state = (wb == TA_KEY1) ? TA_HALF : TA_LOCKED;
            end else if (wr_ctl_any || ta_cnt == '0) begin
               next_ta_state = TA_LOCKED;
            end
         end
         default: next_ta_state = TA_LOCKED;
      endcase
   end

   // [RULE_10] unlock window timing
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ta_state <= TA_LOCKED;
         ta_cnt   <= '0;
      end else begin
         ta_state <= next_ta_state;
         if (next_ta_state == TA_OPEN && !ta_open) begin
            ta_cnt <= TA_WINDOW_CYC;
         end else if (ta_open && ta_cnt != '0) begin
            ta_cnt <= ta_cnt - TA_CNT_ONE;
         end
      end
   end

   // Fields cleared by every reset type
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         counter_run_enable <= 1'b0;
         run_in_sleep       <= 1'b0;
         timeout_flag       <= FLAG_RESET;
         count_clear        <= 1'b0;
      end else begin
         if (wr_ctl) begin
            counter_run_enable <= wb[BIT_RUN];
            run_in_sleep       <= wb[BIT_SLEEP];
         end
         timeout_flag <= next_timeout_flag;
         count_clear  <= next_count_clear;
      end
   end

   // [RULE_07] only power-on clears
   // [RULE_09] power-on presets prescale
   // Held on por_n so a watchdog or other reset cannot disturb them
   always_ff @(posedge core_clk or negedge por_n) begin
      if (!por_n) begin
         dog_reset_flag  <= FLAG_RESET;
         prescale_select <= PRESCALE_POR;
      end else begin
         dog_reset_flag <= next_dog_reset_flag;
         // [RULE_08] prescale select write
         if (wr_ctl) begin
            prescale_select <= wb[PS_MSB:PS_LSB];
         end
      end
   end

   // Sticky interrupt status, mask and the registered interrupt line
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irq_status    <= IRQ_NONE;
         irq_mask      <= IRQ_NONE;
         irq           <= 1'b0;
         dog_reset_req <= 1'b0;
      end else begin
         irq_status    <= next_irq_status;
         irq_mask      <= next_irq_mask;
         irq           <= |(next_irq_status & next_irq_mask);
         // [RULE_06] timeout requests reset
         dog_reset_req <= reset_fire;
      end
   end
endmodule

// File: core/wdctl_pkg.sv
/*
 * Shared constants, types and helper functions of the watchdog control timer.
 * Assumes a single 20 MHz core clock and an AHB-Lite slave with 32-bit data.
 */
package wdctl_pkg;

   // Clock rates; the watchdog tick is an enable derived from the core clock
   localparam int unsigned CORE_HZ     = 20_000_000;
   localparam int unsigned DOG_HZ      = 10_000;
   localparam int unsigned DOG_DIV_CYC = CORE_HZ / DOG_HZ;
   localparam int unsigned DIV_W       = 12;

   // Bus and register geometry
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W  = 8;
   localparam int unsigned IDX_W  = 8;
   localparam logic        HRESP_OKAY = 1'b0;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_DOG_CONTROL  = 8'haa;
   localparam logic [IDX_W-1:0] IDX_TIMED_ACCESS = 8'hb0;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS   = 8'hb1;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK     = 8'hb2;

   // Field positions inside dog_control
   localparam int unsigned BIT_RUN   = 7;
   localparam int unsigned BIT_CLEAR = 6;
   localparam int unsigned BIT_TOF   = 5;
   localparam int unsigned BIT_SLEEP = 4;
   localparam int unsigned BIT_RSTF  = 3;
   localparam int unsigned PS_MSB    = 2;
   localparam int unsigned PS_LSB    = 0;
   localparam int unsigned PS_W      = 3;

   // Reset values
   localparam logic [PS_W-1:0] PRESCALE_POR = 3'h7;
   localparam logic            FLAG_RESET   = 1'b0;

   // Interrupt status and mask layout
   localparam int unsigned IRQ_W       = 2;
   localparam int unsigned IRQ_TIMEOUT = 0;
   localparam int unsigned IRQ_CLEARED = 1;
   localparam logic [IRQ_W-1:0] IRQ_NONE = 2'h0;

   // Configuration enable value that selects general purpose timer use
   localparam int unsigned     CFG_W     = 4;
   localparam logic [CFG_W-1:0] CFG_TIMER = 4'hf;

   // Timed-access unlock keys and open window length in core cycles
   localparam logic [REG_W-1:0] TA_KEY1 = 8'h3c;
   localparam logic [REG_W-1:0] TA_KEY2 = 8'hc3;
   localparam int unsigned      TA_CNT_W = 4;
   localparam logic [TA_CNT_W-1:0] TA_WINDOW_CYC = 4'h8;
   localparam logic [TA_CNT_W-1:0] TA_CNT_ONE    = 4'h1;

   // Counter geometry
   localparam int unsigned COUNT_W = 6;
   localparam int unsigned PRE_W   = 8;
   localparam logic [COUNT_W-1:0] COUNT_ONE = 6'h01;
   localparam logic [PRE_W-1:0]   PRE_ONE   = 8'h01;

   typedef enum logic [1:0] {
      TA_LOCKED = 2'b00,
      TA_HALF   = 2'b01,
      TA_OPEN   = 2'b10
   } wdctl_ta_t;

   // Terminal prescaler count for each select code (division minus one)
   function automatic logic [PRE_W-1:0] wdctl_div_last(input logic [PS_W-1:0] sel);
      logic [PRE_W-1:0] last;
      unique case (sel)
         3'h0: last = 8'h00;
         3'h1: last = 8'h03;
         3'h2: last = 8'h07;
         3'h3: last = 8'h0f;
         3'h4: last = 8'h1f;
         3'h5: last = 8'h3f;
         3'h6: last = 8'h7f;
         3'h7: last = 8'hff;
      endcase
      return last;
   endfunction

endpackage

// File: core/wdctl_cnt_if.sv
/*
 * Carrier between the control logic and the prescaled watchdog counter.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ps
interface wdctl_cnt_if;
   import wdctl_pkg::*;

   logic                  tick;
   logic                  run;
   logic [PS_W-1:0]       prescale;
   logic                  clear_req;
   logic                  clear_done;
   logic                  overflow;
   logic [COUNT_W-1:0]    count;

   modport ctl (output tick, run, prescale, clear_req,
                input  clear_done, overflow, count);
   modport cnt (input  tick, run, prescale, clear_req,
                output clear_done, overflow, count);
endinterface

// File: core/wdctl_counter.sv
/*
 * Prescaler and watchdog count with clear handshake and overflow pulse.
 * Assumes tick is a one-cycle enable at the watchdog clock rate.
 */
`timescale 1ns/1ps
module wdctl_counter (
   input  wire logic  core_clk,
   input  wire logic  resetn,
   wdctl_cnt_if.cnt   cnt_bus
);
   import wdctl_pkg::*;

   logic [PRE_W-1:0]   pre_cnt;
   logic [COUNT_W-1:0] count;
   logic               clear_done;
   logic               overflow;
   wire  [PRE_W-1:0]   pre_last;
   wire                pre_wrap;
   wire                step;
   wire                wrap;

   // Prescaler terminal and counter step decode
   assign pre_last = wdctl_div_last(cnt_bus.prescale);
   assign pre_wrap = (pre_cnt == pre_last);
   assign step     = cnt_bus.tick & cnt_bus.run & pre_wrap & ~cnt_bus.clear_req;
   assign wrap     = step & (count == {COUNT_W{1'b1}});

   assign cnt_bus.count      = count;
   assign cnt_bus.clear_done = clear_done;
   assign cnt_bus.overflow   = overflow;

   // Clear acts on a watchdog tick, so a pending clear is visible for a while
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pre_cnt    <= '0;
         count      <= '0;
         clear_done <= 1'b0;
         overflow   <= 1'b0;
      end else begin
         clear_done <= cnt_bus.tick & cnt_bus.clear_req;
         overflow   <= wrap;
         if (cnt_bus.tick & cnt_bus.clear_req) begin
            pre_cnt <= '0;
            count   <= '0;
         end else if (cnt_bus.tick & cnt_bus.run) begin
            pre_cnt <= pre_wrap ? '0 : pre_cnt + PRE_ONE;
            if (pre_wrap) begin
               count <= count + COUNT_ONE;
            end
         end
      end
   end
endmodule

// File: verification/wdctl_top_props.sv
/*
 * Port checker of the watchdog control timer, bound into wdctl_top.
 * Assumes one clock core_clk, async active-low resetn and a single AHB slave.
 */
`timescale 1ns/1ps
module wdctl_top_props
   import wdctl_pkg::*;
#(
   parameter int unsigned BASE_DIV_CYC = 4
) (
   input wire logic                  core_clk,
   input wire logic                  resetn,
   input wire logic                  hsel,
   input wire logic [ADDR_W-1:0]     haddr,
   input wire logic [1:0]            htrans,
   input wire logic                  hwrite,
   input wire logic [DATA_W-1:0]     hwdata,
   input wire logic                  hready,
   input wire logic [DATA_W-1:0]     hrdata,
   input wire logic                  hreadyout,
   input wire logic                  hresp,
   input wire logic [CFG_W-1:0]      timer_config_enable,
   input wire logic                  irq,
   input wire logic                  dog_reset_req
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);

   // Address phases taken by the slave
   logic rd_req;
   logic wr_req;
   assign rd_req = hsel && htrans[1] && hready && !hwrite;
   assign wr_req = hsel && htrans[1] && hready && hwrite;

   ready_after_reset_a: assert property (1'b1 |=> hreadyout)
      else $error("hreadyout low after reset");
   resp_okay_a: assert property (hreadyout |-> hresp == HRESP_OKAY)
      else $error("hresp not OKAY");
   rdata_idle_a: assert property (!rd_req |=> hrdata == '0)
      else $error("hrdata not zero outside a read");
   rdata_upper_a: assert property (rd_req |=> hrdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   // Timed-access keys and unmapped places read as zero
   unmapped_zero_a: assert property (rd_req && haddr[9:2] != IDX_DOG_CONTROL &&
      haddr[9:2] != IDX_IRQ_STATUS && haddr[9:2] != IDX_IRQ_MASK |=> hrdata == '0)
      else $error("unmapped read not zero");
   reset_pulse_a: assert property (dog_reset_req |=> !dog_reset_req)
      else $error("reset request longer than one cycle");
   // The request is registered from the mode seen one edge earlier
   timer_no_reset_a: assert property (dog_reset_req |->
      $past(timer_config_enable) != CFG_TIMER)
      else $error("reset request in timer use");
   // Mask cleared by a write silences irq two edges after the data edge
   mask_off_a: assert property ((wr_req && haddr[9:2] == IDX_IRQ_MASK) ##1
      (hwdata[IRQ_W-1:0] == IRQ_NONE) |=> ##1 !irq)
      else $error("irq high with mask cleared");
endmodule

bind wdctl_top wdctl_top_props #(.BASE_DIV_CYC(BASE_DIV_CYC)) wdctl_top_props_inst (
   .core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .timer_config_enable(timer_config_enable),
   .irq(irq), .dog_reset_req(dog_reset_req));

// File: verification/testbench.sv
/*
 * Self-checking bench of the watchdog control timer over AHB-Lite.
 * Assumes the one slave drives hready through hreadyout and answers OKAY.
 */
`timescale 1ns/1ps
module testbench;
   import wdctl_pkg::*;
   localparam logic [31:0] A_CTL = 32'h0000_02a8;
   localparam logic [31:0] A_KEY = 32'h0000_02c0;
   localparam logic [31:0] A_STS = 32'h0000_02c4;
   localparam logic [31:0] A_MSK = 32'h0000_02c8;
   logic        core_clk, resetn, por_n, hsel, hwrite, sleep_mode;
   logic [31:0] haddr, hwdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [3:0]  cfg;
   wire  [31:0] hrdata;
   wire         hready, hreadyout, hresp, irq, dog_reset_req;
   int          n_fail, check_count, cycles, req_count;

   assign hready = hreadyout;

   // Short tick so an overflow takes 256 cycles at division 1
   wdctl_top #(.BASE_DIV_CYC(4)) wdctl_top_inst (
      .core_clk(core_clk), .resetn(resetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .timer_config_enable(cfg), .sleep_mode(sleep_mode), .irq(irq),
      .dog_reset_req(dog_reset_req));

   always #25 core_clk = ~core_clk;

   // Cycle limit and reset request counter; the pulse is one cycle wide
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (dog_reset_req === 1'b1) req_count <= req_count + 1;
      if (cycles == 20000) begin
         n_fail = n_fail + 1;
         finish_test;
      end
   end

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One single transfer; the request holds until hready is seen high
   task automatic bus_cycle(input logic [31:0] a, input logic w, input logic [31:0] d,
                            output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge core_clk);
      while (hready !== 1'b1) @(posedge core_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      @(posedge core_clk);
      while (hready !== 1'b1) @(posedge core_clk);
      q = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus_cycle(a, 1'b1, d, q);
   endtask

   task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus_cycle(a, 1'b0, 32'h0, q);
      check(name, exp, q);
   endtask

   // Unlock keys back to back so the control write lands inside the window
   // unlock before writing
   task automatic ctl_write(input logic [7:0] d);
      wr(A_KEY, {24'h0, TA_KEY1});
      wr(A_KEY, {24'h0, TA_KEY2});
      wr(A_CTL, {24'h0, d});
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic do_reset(input logic por);
      resetn <= 1'b0;
      por_n <= ~por;
      idle(8);
      resetn <= 1'b1;
      por_n <= 1'b1;
      idle(2);
   endtask

   initial begin
      int i;
      core_clk = 1'b0;
      resetn = 1'b0;
      por_n = 1'b0;
      {hsel, hwrite, sleep_mode} = 3'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      cfg = CFG_TIMER;
      {n_fail, check_count, cycles, req_count} = '0;
      do_reset(1'b1);
      rd_chk("ctl after power-on", A_CTL, 32'h07);
      rd_chk("unmapped", 32'h0, 32'h0);
      rd_chk("key register", A_KEY, 32'h0);
      wr(A_CTL, 32'h80);
      rd_chk("locked write", A_CTL, 32'h07);
      // Timer at division 1, masked interrupt
      ctl_write(8'h80);
      rd_chk("run set", A_CTL, 32'h80);
      idle(300);
      check("irq masked", 32'h0, {31'h0, irq});
      rd_chk("timeout flag", A_CTL, 32'ha0);
      wr(A_MSK, 32'h1);
      idle(3);
      check("irq raised", 32'h1, {31'h0, irq});
      rd_chk("status timeout", A_STS, 32'h1);
      idle(2);
      check("irq cleared", 32'h0, {31'h0, irq});
      wr(A_MSK, 32'h0);
      ctl_write(8'h80);
      rd_chk("flag cleared", A_CTL, 32'h80);
      // Clear restarts the count; the request stays visible until the next tick
      ctl_write(8'hc0);
      rd_chk("clear pending", A_CTL, 32'hc0);
      idle(10);
      rd_chk("clear finished", A_CTL, 32'h80);
      rd_chk("clear done", A_STS, 32'h2);
      idle(200);
      rd_chk("no early timeout", A_STS, 32'h0);
      sleep_mode <= 1'b1;
      idle(300);
      rd_chk("halted in sleep", A_STS, 32'h0);
      ctl_write(8'h90);
      idle(300);
      rd_chk("runs in sleep", A_STS, 32'h1);
      sleep_mode <= 1'b0;
      // Watchdog use: run bit off, yet the overflow still requests a reset
      ctl_write(8'h10);
      cfg <= 4'h0;
      for (i = 0; i < 300 && req_count == 0; i++) @(posedge core_clk);
      check("reset requests", 32'h1, req_count);
      rd_chk("reset flag set", A_CTL, 32'h38);
      cfg <= CFG_TIMER;
      do_reset(1'b0);
      rd_chk("system reset keeps", A_CTL, 32'h08);
      do_reset(1'b1);
      rd_chk("power-on clears", A_CTL, 32'h07);
      // Division 4: 64 steps of 16 cycles before the count wraps
      ctl_write(8'h81);
      idle(900);
      rd_chk("no wrap at division 4", A_STS, 32'h0);
      idle(200);
      rd_chk("wrap at division 4", A_STS, 32'h1);
      finish_test;
   end
endmodule
